// ---- hdl/pso_top.sv ----
// Sync channel update machinery, second interrupt set and output override for four PWM channels.
// What this block does
// - Mode 0 unlock updates period, duty, dead-time.
// - Modes 1,2 unlock updates period, dead-time only.
// - Unlock self-clears when done; zero write ignored.
// - Control register shows live update period counter.
// - Automatic update every update period plus one.
// - Buffer register double-buffers requested update period.
// - Enable register writes ones set mask bits.
// - Disable register writes ones clear mask bits.
// - Mask is read-only, resets to zero.
// - Sticky comparison-updated flags in bits 16-23.
// - Sticky comparison-match flags in bits 8-15.
// - Sticky underrun error flag at bit 3.
// - Write-ready flag at bit 0 permits writes.
// - Status read returns flags, then clears them.
// - Override levels: low bits 16-19, high 0-3.
// - Low select picks dead-time or override level.
// - High select picks dead-time or override level.
// - Mode 0 manual, 1 auto, 2 DMA, 3 reserved.
// - Only lockstep-flagged channels are synchronous.
// - Mode 1 sets write-ready on elapse; 0 never.
`timescale 1ns/1ps
`default_nettype none
module pso_top
  import pso_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Events from the counters and comparison units.
  input wire logic period_start_i,
  input wire logic [7:0] cmp_updated_i,
  input wire logic [7:0] cmp_match_i,
  input wire logic update_underrun_i,
  // Dead-time generator outputs.
  input wire logic [3:0] deadtime_low_out_i,
  input wire logic [3:0] deadtime_high_out_i,
  // Update strobes to the channel double buffers.
  output logic [3:0] sync_channels_o,
  output logic upd_period_dt_o,
  output logic upd_duty_o,
  // Pins and interrupt.
  output logic [3:0] low_side_pin_o,
  output logic [3:0] high_side_pin_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_q, rst_n;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are captured independently.
  logic aw_full_q, w_full_q, bvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  assign s_axi_awready_o = !aw_full_q;
  assign s_axi_wready_o = !w_full_q;
  assign s_axi_bvalid_o = bvalid_q;
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
  wire wr_full_word = (w_strb_q == 4'hF);
  wire wr_unlock = wr_fire && aw_addr_q == PSO_OFF_UNLOCK;
  wire wr_mode = wr_fire && aw_addr_q == PSO_OFF_SYNC_MODE;
  wire wr_ctl = wr_fire && aw_addr_q == PSO_OFF_UPD_CTL;
  wire wr_buf = wr_fire && aw_addr_q == PSO_OFF_UPD_BUF;
  wire wr_set = wr_fire && aw_addr_q == PSO_OFF_IRQ_SET;
  wire wr_clr = wr_fire && aw_addr_q == PSO_OFF_IRQ_CLR;
  wire wr_ovr = wr_fire && aw_addr_q == PSO_OFF_OVR_LVL;
  wire wr_sel = wr_fire && aw_addr_q == PSO_OFF_OUT_SEL;
  wire wr_hit = wr_unlock || wr_mode || wr_ctl || wr_buf || wr_set || wr_clr || wr_ovr || wr_sel;
  wire wr_ok = wr_hit && wr_full_word;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= PSO_RESET_WORD;
      w_strb_q <= 4'h0;
      s_axi_bresp_o <= PSO_AXI_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        s_axi_bresp_o <= wr_ok ? PSO_AXI_OKAY : PSO_AXI_SLVERR;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Synchronous mode, update period and unlock.
  logic [3:0] sync_q, upr_q, upr_buf_q, upr_cnt_q;
  logic [1:0] mode_q;
  logic unlock_q, buf_pend_q;
  assign sync_channels_o = sync_q;
  wire auto_mode = (mode_q == PSO_MODE_AUTO) || (mode_q == PSO_MODE_DMA);
  wire upr_elapsed = period_start_i && auto_mode && (upr_cnt_q == upr_q);
  wire unlock_done = unlock_q && period_start_i;
  // modes 1,2 period and dead-time only
  assign upd_period_dt_o = unlock_done || upr_elapsed;
  assign upd_duty_o = (unlock_done && mode_q == PSO_MODE_MANUAL) || upr_elapsed;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 4'h0;
      mode_q <= PSO_MODE_MANUAL;
      upr_q <= 4'h0;
      upr_buf_q <= 4'h0;
      buf_pend_q <= 1'b0;
      upr_cnt_q <= 4'h0;
      unlock_q <= 1'b0;
    end else begin
      if (wr_mode && wr_full_word) begin
        sync_q <= w_data_q[3:0];
        mode_q <= w_data_q[PSO_MODE_LSB +: 2];
      end
      if (wr_unlock && wr_full_word && w_data_q[0]) begin
        unlock_q <= 1'b1;
      end else if (unlock_done) begin
        unlock_q <= 1'b0;
      end
      if (wr_ctl && wr_full_word) begin
        upr_q <= w_data_q[PSO_UPR_LSB +: 4];
      end
      if (wr_buf && wr_full_word) begin
        upr_buf_q <= w_data_q[PSO_UPR_LSB +: 4];
        buf_pend_q <= 1'b1;
      end
      if (upr_elapsed) begin
        upr_cnt_q <= 4'h0;
        if (buf_pend_q && !(wr_buf && wr_full_word)) begin
          upr_q <= upr_buf_q;
          buf_pend_q <= 1'b0;
        end
      end else if (period_start_i && auto_mode) begin
        upr_cnt_q <= upr_cnt_q + 4'h1;
      end else if (!auto_mode) begin
        upr_cnt_q <= 4'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Second interrupt set: mask and sticky flags.
  logic [31:0] mask_q, flags_q;
  logic rd_clear;
  // write-ready only in mode 1 or 2
  wire write_ready_flag_set = upr_elapsed && (mode_q != PSO_MODE_MANUAL);
  wire [31:0] flag_set = {8'h00, cmp_updated_i, cmp_match_i, 4'h0, update_underrun_i, 2'b00, write_ready_flag_set};
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= PSO_RESET_WORD;
      flags_q <= PSO_RESET_WORD;
    end else begin
      if (wr_set && wr_full_word) begin
        mask_q <= mask_q | (w_data_q & PSO_IRQ_BITS);
      end else if (wr_clr && wr_full_word) begin
        mask_q <= mask_q & ~(w_data_q & PSO_IRQ_BITS);
      end
      flags_q <= ((rd_clear ? 32'h0 : flags_q) | flag_set) & PSO_IRQ_BITS;
    end
  end
  assign irq_o = |(flags_q & mask_q);
  ////////////////////////////////////////////////////////////////////////////
  // Override levels and output select.
  logic [31:0] ovr_q, sel_q;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ovr_q <= PSO_RESET_WORD;
      sel_q <= PSO_RESET_WORD;
    end else begin
      if (wr_ovr && wr_full_word) begin
        ovr_q <= w_data_q & 32'h000F000F;
      end
      if (wr_sel && wr_full_word) begin
        sel_q <= w_data_q & 32'h000F000F;
      end
    end
  end
  wire [3:0] low_next = (sel_q[PSO_LOW_LSB +: 4] & ovr_q[PSO_LOW_LSB +: 4]) |
                        (~sel_q[PSO_LOW_LSB +: 4] & deadtime_low_out_i);
  wire [3:0] high_next = (sel_q[3:0] & ovr_q[3:0]) | (~sel_q[3:0] & deadtime_high_out_i);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      low_side_pin_o <= 4'h0;
      high_side_pin_o <= 4'h0;
    end else begin
      low_side_pin_o <= low_next;
      high_side_pin_o <= high_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  logic rvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  wire rd_take = s_axi_arvalid_i && !rvalid_q;
  wire [7:0] ra = s_axi_araddr_i;
  wire [31:0] rd_mux =
    (ra == PSO_OFF_SYNC_MODE) ? {14'h0, mode_q, 12'h0, sync_q} :
    (ra == PSO_OFF_UNLOCK) ? {31'h0, unlock_q} :
    (ra == PSO_OFF_UPD_CTL) ? {24'h0, upr_cnt_q, upr_q} :
    (ra == PSO_OFF_IRQ_MASK) ? mask_q :
    (ra == PSO_OFF_IRQ_FLAGS) ? flags_q :
    (ra == PSO_OFF_OVR_LVL) ? ovr_q :
    (ra == PSO_OFF_OUT_SEL) ? sel_q : 32'h0;
  wire rd_hit = ra == PSO_OFF_SYNC_MODE || ra == PSO_OFF_UNLOCK || ra == PSO_OFF_UPD_CTL ||
                ra == PSO_OFF_IRQ_MASK || ra == PSO_OFF_IRQ_FLAGS || ra == PSO_OFF_OVR_LVL ||
                ra == PSO_OFF_OUT_SEL;
  assign rd_clear = rd_take && ra == PSO_OFF_IRQ_FLAGS;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      s_axi_rdata_o <= PSO_RESET_WORD;
      s_axi_rresp_o <= PSO_AXI_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= rd_hit ? PSO_AXI_OKAY : PSO_AXI_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pso_pkg.sv ----
// Package with register map, field layout and encodings of the sync update and override block.
package pso_pkg;
  localparam logic [7:0] PSO_OFF_UNLOCK = 8'h28;
  localparam logic [7:0] PSO_OFF_SYNC_MODE = 8'h20;
  localparam logic [7:0] PSO_OFF_UPD_CTL = 8'h2C;
  localparam logic [7:0] PSO_OFF_UPD_BUF = 8'h30;
  localparam logic [7:0] PSO_OFF_IRQ_SET = 8'h34;
  localparam logic [7:0] PSO_OFF_IRQ_CLR = 8'h38;
  localparam logic [7:0] PSO_OFF_IRQ_MASK = 8'h3C;
  localparam logic [7:0] PSO_OFF_IRQ_FLAGS = 8'h40;
  localparam logic [7:0] PSO_OFF_OVR_LVL = 8'h44;
  localparam logic [7:0] PSO_OFF_OUT_SEL = 8'h48;
  localparam int PSO_UPR_LSB = 0;
  localparam int PSO_CNT_LSB = 4;
  localparam int PSO_MODE_LSB = 16;
  localparam int PSO_WRITE_READY_FLAG_BIT = 0;
  localparam int PSO_UPDATE_UNDERRUN_ERROR_BIT = 3;
  localparam int PSO_COMPARISON_MATCH_FLAG_LSB = 8;
  localparam int PSO_COMPARISON_UPDATED_FLAG_LSB = 16;
  localparam int PSO_LOW_LSB = 16;
  localparam logic [31:0] PSO_IRQ_BITS = 32'h00FFFF09;
  localparam logic [31:0] PSO_RESET_WORD = 32'h00000000;
  localparam logic [1:0] PSO_AXI_OKAY = 2'h0;
  localparam logic [1:0] PSO_AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PSO_MODE_MANUAL = 2'b00,
    PSO_MODE_AUTO = 2'b01,
    PSO_MODE_DMA = 2'b10,
    PSO_MODE_RSVD = 2'b11
  } pso_mode_t;
endpackage

// ---- tb/pso_sva.sv ----
// Checker for bus answers and update strobes of the sync update block.
`timescale 1ns/1ps
`default_nettype none
module pso_sva
  import pso_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register bus.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Update events.
  input wire logic period_start_i,
  input wire logic upd_period_dt_o,
  input wire logic upd_duty_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire ar = s_axi_arvalid_i && s_axi_arready_o;
  wire aw = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  //////////////////////////////////////////
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_arrdy; s_axi_arready_o == !s_axi_rvalid_o; endproperty
  a_arrdy: assert property (p_arrdy) else $error("read ready wrong");
  property p_bans; aw |-> ##[1:2] s_axi_bvalid_o; endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  property p_wo; ar && s_axi_araddr_i == 8'h30 |=> s_axi_rresp_o == PSO_AXI_SLVERR && s_axi_rdata_o == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("write-only read answered");
  property p_irqb; ar && (s_axi_araddr_i == 8'h3C || s_axi_araddr_i == 8'h40) |=> (s_axi_rdata_o & ~PSO_IRQ_BITS) == 0;
  endproperty
  a_irqb: assert property (p_irqb) else $error("reserved flag bits set");
  property p_cnt; ar && s_axi_araddr_i == 8'h2C |=> s_axi_rdata_o[31:8] == 24'h0 && s_axi_rresp_o == PSO_AXI_OKAY;
  endproperty
  a_cnt: assert property (p_cnt) else $error("period register read wrong");
  property p_duty; upd_duty_o |-> upd_period_dt_o; endproperty
  a_duty: assert property (p_duty) else $error("duty update alone");
  property p_ps; upd_period_dt_o |-> period_start_i; endproperty
  a_ps: assert property (p_ps) else $error("update off period start");
  c_dty: cover property (upd_duty_o);
  c_pdt: cover property (upd_period_dt_o && !upd_duty_o);
  c_wo: cover property (ar && s_axi_araddr_i == 8'h30);
endmodule
bind pso_top pso_sva pso_sva_inst (.clk_sys_i, .nrst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .period_start_i, .upd_period_dt_o, .upd_duty_o);
`default_nettype wire

// ---- tb/pso_stage.sv ----
// Power stage model: one half bridge per channel driven by the two pins.
`timescale 1ns/1ps
`default_nettype none
module pso_stage (
  // Gate drives.
  input wire logic [3:0] low_i,
  input wire logic [3:0] high_i,
  // Bridge node level and shoot-through flag.
  output logic [3:0] node_o,
  output logic shoot_o
);
  assign node_o = high_i & ~low_i;
  assign shoot_o = |(low_i & high_i);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the sync update and override block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pso_pkg::*;
  logic clk = '0, nrst = '0, awv = '0, wv = '0, arv = '0, ps = '0, ur = '0;
  logic [7:0] awa = '0, ara = '0, cu = '0, cm = '0;
  logic [31:0] wd = '0, rdt, v;
  logic [3:0] dl = 4'hA, dh = 4'h5, sy, lo, hi, nd;
  logic awr, wrd, bv, arr, rv, pdt, dty, irq, sh;
  logic [1:0] br, rr, rs;
  int miscompares = 0, cmp_count = 0, npdt = 0, ndty = 0, n0, m0;
  pso_top pso_top_inst (.clk_sys_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .period_start_i(ps), .cmp_updated_i(cu), .cmp_match_i(cm), .update_underrun_i(ur), .deadtime_low_out_i(dl),
    .deadtime_high_out_i(dh), .sync_channels_o(sy), .upd_period_dt_o(pdt), .upd_duty_o(dty),
    .low_side_pin_o(lo), .high_side_pin_o(hi), .irq_o(irq));
  pso_stage pso_stage_inst (.low_i(lo), .high_i(hi), .node_o(nd), .shoot_o(sh));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (pdt === 1'b1) npdt++;
    if (dty === 1'b1) ndty++;
  end
  //////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(ref logic s);
    #1;
    while (s !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    wt(awr);
    awv <= 1'b0;
    wv <= 1'b0;
    wt(bv);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    ara <= a;
    arv <= 1'b1;
    wt(arr);
    arv <= 1'b0;
    wt(rv);
    rs = rr;
    chk("read", rdt, e);
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      ps <= 1'b1;
      @(posedge clk);
      ps <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) rc(8'h2C + 8'(4 * i), 32'h0);
    rc(8'h30, 32'h0);
    chk("resp", {30'h0, rs}, {30'h0, PSO_AXI_SLVERR});
    $display("test reset and map done");
    wr(8'h34, 32'h00FFFF09);
    rc(8'h3C, 32'h00FFFF09);
    wr(8'h38, 32'h00000009);
    rc(8'h3C, 32'h00FFFF00);
    wr(8'h34, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    chk("bresp", {30'h0, br}, {30'h0, PSO_AXI_SLVERR});
    rc(8'h3C, 32'h00FFFF00);
    wr(8'h34, 32'h00000009);
    cu <= 8'hA5;
    cm <= 8'h3C;
    ur <= 1'b1;
    @(posedge clk);
    cu <= 8'h0;
    cm <= 8'h0;
    ur <= 1'b0;
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rc(8'h40, 32'h00A53C08);
    rc(8'h40, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h38, 32'h00FFFF09);
    $display("test flags done");
    wr(8'h44, 32'h00030006);
    wr(8'h48, 32'h000C0003);
    // The pins are registered, so let the edge that loads them pass first.
    @(posedge clk);
    chk("low", {28'h0, lo}, 32'h2);
    chk("high", {28'h0, hi}, 32'h6);
    dl <= 4'h5;
    dh <= 4'hA;
    repeat (2) @(posedge clk);
    chk("low", {28'h0, lo}, 32'h1);
    chk("high", {28'h0, hi}, 32'hA);
    $display("test override done");
    wr(8'h20, 32'h0001000F);
    chk("sync", {28'h0, sy}, 32'hF);
    wr(8'h30, 32'h2);
    rc(8'h2C, 32'h0);
    n0 = npdt;
    pulse(1);
    chk("auto", npdt - n0, 32'h1);
    rc(8'h2C, 32'h2);
    pulse(1);
    rc(8'h2C, 32'h12);
    pulse(2);
    chk("auto", npdt - n0, 32'h2);
    rc(8'h40, 32'h1);
    n0 = npdt;
    m0 = ndty;
    wr(8'h28, 32'h1);
    rc(8'h28, 32'h1);
    pulse(1);
    chk("unlock", npdt - n0, 32'h1);
    chk("duty", ndty - m0, 32'h0);
    rc(8'h28, 32'h0);
    $display("test auto update done");
    wr(8'h20, 32'h0000000F);
    wr(8'h28, 32'h1);
    wr(8'h28, 32'h0);
    rc(8'h28, 32'h1);
    pulse(1);
    chk("unlock", npdt - n0, 32'h2);
    chk("duty", ndty - m0, 32'h1);
    rc(8'h28, 32'h0);
    rc(8'h40, 32'h0);
    $display("test manual update done");
    end_of_test();
  end
endmodule
`default_nettype wire
